// File: src/mic_pkg.sv
package mic_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses of 32-bit words)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL_REG = 8'h00;
    localparam logic [7:0] ADDR_PERIPH_FLAG_REG_ONE = 8'h04;
    localparam logic [7:0] ADDR_PERIPH_FLAG_REG_TWO = 8'h08;
    localparam logic [7:0] ADDR_PERIPH_ENABLE_REG_ONE = 8'h0c;
    localparam logic [7:0] ADDR_PERIPH_ENABLE_REG_TWO = 8'h10;
    localparam logic [7:0] ADDR_OPTION_REG = 8'h14;
    localparam logic [7:0] ADDR_CORE_STATUS = 8'h18;
    // ------------------------------------------------------------------
    // Control register fields, and option register edge select
    // ------------------------------------------------------------------
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_PERIPH_GROUP_ENABLE = 6;
    localparam int BIT_TIMER0_OVERFLOW_ENABLE = 5;
    localparam int BIT_EXT_IRQ_ENABLE = 4;
    localparam int BIT_PORT_CHANGE_ENABLE = 3;
    localparam int BIT_TIMER0_OVERFLOW_FLAG = 2;
    localparam int BIT_EXT_IRQ_FLAG = 1;
    localparam int BIT_PORT_CHANGE_FLAG = 0;
    localparam int BIT_EXT_EDGE_SELECT = 6;
    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_INTERRUPT_CONTROL_REG = 8'h00;
    localparam logic [7:0] RST_PERIPH_REG = 8'h00;
    localparam logic [7:0] RST_OPTION_REG = 8'hff;
    localparam logic [12:0] IRQ_VECTOR_ADDR = 13'h0004;
    localparam int PERIPH_SOURCES = 9;
    localparam logic [1:0] AXI_RESP_OKAY = 2'b00;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'b10;
endpackage : mic_pkg

// File: src/mic_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module mic_edge_detect #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] sig_i, // Sampled signals.
    output logic [WIDTH-1:0] rise_o, // One-cycle rising edge pulses.
    output logic [WIDTH-1:0] fall_o // One-cycle falling edge pulses.
);
    logic [WIDTH-1:0] prev_ff;
    logic primed_ff;

    // Edges are only reported after the first sample so reset looks quiet.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            prev_ff <= '0;
            primed_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= sig_i;
            primed_ff <= 1'b1;
        end
    end

    assign rise_o = primed_ff ? (sig_i & ~prev_ff) : '0;
    assign fall_o = primed_ff ? (~sig_i & prev_ff) : '0;
endmodule // mic_edge_detect
`default_nettype wire

// File: src/mic_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
module mic_axil_slave (
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read response valid.
    input wire logic s_axi_rready, // Read response ready.
    output logic wr_en_o, // One-cycle register write pulse.
    output logic [7:0] wr_addr_o, // Register write address.
    output logic [7:0] wr_data_o, // Register write data, low byte.
    input wire logic wr_ok_i, // Write address is mapped.
    output logic rd_en_o, // One-cycle register read pulse.
    output logic [7:0] rd_addr_o, // Register read address.
    input wire logic [7:0] rd_data_i, // Register read data.
    input wire logic rd_ok_i // Read address is mapped.
);
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wlane_ff;
    logic nxt_bvalid;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    assign nxt_bvalid = (aw_got_ff && w_got_ff && !s_axi_bvalid) || (s_axi_bvalid && !s_axi_bready);

    // Each ready leaves a flip-flop loaded with what its channel's state allows next cycle.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !nxt_bvalid && !aw_got_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !nxt_bvalid && !w_got_ff && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= !rd_en_o && !(s_axi_rvalid && !s_axi_rready);
        end
    end
    assign wr_addr_o = awaddr_ff;
    assign wr_data_o = wdata_ff;
    assign wr_en_o = aw_got_ff && w_got_ff && !s_axi_bvalid && wlane_ff;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY();
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (aw_got_ff && w_got_ff && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok_i ? mic_pkg::AXI_RESP_OKAY : mic_pkg::AXI_RESP_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [1:0] AXI_OKAY();
        return mic_pkg::AXI_RESP_OKAY;
    endfunction

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign rd_en_o = s_axi_arvalid && s_axi_arready;
    assign rd_addr_o = s_axi_araddr;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mic_pkg::AXI_RESP_OKAY;
        end
        else if (rd_en_o)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_data_i};
            s_axi_rresp <= rd_ok_i ? mic_pkg::AXI_RESP_OKAY : mic_pkg::AXI_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // mic_axil_slave
`default_nettype wire

// File: src/mic_interrupt_control.sv
`timescale 1ns/1ns
`default_nettype none
module mic_interrupt_control #(
    parameter int PERIPH_WIDTH = 8 // Width of each peripheral flag register.
) (
    input wire logic sys_clk_i, // 10 MHz system clock.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic [7:0] s_axi_awaddr, // AXI4-Lite write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read response valid.
    input wire logic s_axi_rready, // Read response ready.
    input wire logic ext_irq_pin_i, // External interrupt pin level.
    input wire logic [3:0] upper_port_pins_i, // Upper port pins 7:4.
    input wire logic timer0_rollover_i, // Pulse: timer0 count wrapped FFh to 00h.
    input wire logic [PERIPH_WIDTH-1:0] periph_evt_one_i, // Peripheral event pulses, group one.
    input wire logic [PERIPH_WIDTH-1:0] periph_evt_two_i, // Peripheral event pulses, group two.
    input wire logic instr_cycle_i, // Pulse: core instruction cycle boundary.
    input wire logic sleeping_i, // Core is asleep.
    input wire logic irq_ack_i, // Pulse: core accepts the vector.
    input wire logic return_from_irq_instr_i, // Pulse: return-from-interrupt executed.
    output logic irq_req_o, // Interrupt request to the core.
    output logic wake_o, // Wake request to the sleeping core.
    output logic vector_load_o, // Pulse: load program counter with vector.
    output logic push_return_o, // Pulse: push return address on stack.
    output logic [12:0] vector_addr_o // Interrupt vector address.
);
    logic [7:0] interrupt_control_reg_ff;
    logic [PERIPH_WIDTH-1:0] periph_flag_reg_one_ff;
    logic [PERIPH_WIDTH-1:0] periph_flag_reg_two_ff;
    logic [PERIPH_WIDTH-1:0] periph_enable_reg_one_ff;
    logic [PERIPH_WIDTH-1:0] periph_enable_reg_two_ff;
    logic [7:0] option_reg_ff;
    logic [3:0] port_latch_ff;
    logic [1:0] req_pipe_ff;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_ok;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_ok;
    logic pin_rise;
    logic pin_fall;
    logic ext_edge;
    logic port_change;
    logic periph_pending;
    logic core_pending;
    logic any_pending;

    function automatic logic [7:0] pad8(input logic [PERIPH_WIDTH-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        r[PERIPH_WIDTH-1:0] = v;
        return r;
    endfunction

    function automatic logic [PERIPH_WIDTH-1:0] flag_update(input logic [PERIPH_WIDTH-1:0] cur,
        input logic [PERIPH_WIDTH-1:0] evt, input logic wr, input logic [7:0] data);
        logic [PERIPH_WIDTH-1:0] r;
        r = wr ? data[PERIPH_WIDTH-1:0] : cur;
        return r | evt;
    endfunction

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    mic_axil_slave u_bus (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_ok_i(wr_ok),
        .rd_en_o(rd_en),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok)
    );

    function automatic logic is_mapped(input logic [7:0] a, input logic wr);
        return (a == mic_pkg::ADDR_INTERRUPT_CONTROL_REG) || (a == mic_pkg::ADDR_PERIPH_FLAG_REG_ONE)
            || (a == mic_pkg::ADDR_PERIPH_FLAG_REG_TWO) || (a == mic_pkg::ADDR_PERIPH_ENABLE_REG_ONE)
            || (a == mic_pkg::ADDR_PERIPH_ENABLE_REG_TWO) || (a == mic_pkg::ADDR_OPTION_REG)
            || (!wr && (a == mic_pkg::ADDR_CORE_STATUS));
    endfunction

    assign wr_ok = is_mapped(wr_addr, 1'b1);
    assign rd_ok = is_mapped(rd_addr, 1'b0);

    always_comb
    begin
        case (rd_addr)
            mic_pkg::ADDR_INTERRUPT_CONTROL_REG: rd_data = interrupt_control_reg_ff;
            mic_pkg::ADDR_PERIPH_FLAG_REG_ONE: rd_data = pad8(periph_flag_reg_one_ff);
            mic_pkg::ADDR_PERIPH_FLAG_REG_TWO: rd_data = pad8(periph_flag_reg_two_ff);
            mic_pkg::ADDR_PERIPH_ENABLE_REG_ONE: rd_data = pad8(periph_enable_reg_one_ff);
            mic_pkg::ADDR_PERIPH_ENABLE_REG_TWO: rd_data = pad8(periph_enable_reg_two_ff);
            mic_pkg::ADDR_OPTION_REG: rd_data = option_reg_ff;
            mic_pkg::ADDR_CORE_STATUS: rd_data = {5'h00, wake_o, irq_req_o, any_pending};
            default: rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    mic_edge_detect #(
        .WIDTH(1)
    ) u_pin_edge (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .sig_i(ext_irq_pin_i),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    assign ext_edge = option_reg_ff[mic_pkg::BIT_EXT_EDGE_SELECT] ? pin_rise : pin_fall;

    // Port change compares against the pin value latched when the last change was seen.
    assign port_change = |(upper_port_pins_i ^ port_latch_ff);

    // Reset loads the pins as they stand, so leaving reset flags no change.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            port_latch_ff <= upper_port_pins_i;
        end
        else if (port_change)
        begin
            port_latch_ff <= upper_port_pins_i;
        end
    end

    // ------------------------------------------------------------------
    // Control register: flags, enables and global enable
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            interrupt_control_reg_ff <= mic_pkg::RST_INTERRUPT_CONTROL_REG;
        end
        else
        begin
            if (wr_en && wr_addr == mic_pkg::ADDR_INTERRUPT_CONTROL_REG)
            begin
                interrupt_control_reg_ff <= wr_data;
            end
            if (irq_ack_i)
            begin
                interrupt_control_reg_ff[mic_pkg::BIT_GLOBAL_IRQ_ENABLE] <= 1'b0;
            end
            else if (return_from_irq_instr_i)
            begin
                interrupt_control_reg_ff[mic_pkg::BIT_GLOBAL_IRQ_ENABLE] <= 1'b1;
            end
            // Hardware sets win over a software clear in the same cycle.
            if (ext_edge)
            begin
                interrupt_control_reg_ff[mic_pkg::BIT_EXT_IRQ_FLAG] <= 1'b1;
            end
            if (timer0_rollover_i)
            begin
                interrupt_control_reg_ff[mic_pkg::BIT_TIMER0_OVERFLOW_FLAG] <= 1'b1;
            end
            if (port_change)
            begin
                interrupt_control_reg_ff[mic_pkg::BIT_PORT_CHANGE_FLAG] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Peripheral flag and enable registers, and option register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            periph_flag_reg_one_ff <= mic_pkg::RST_PERIPH_REG[PERIPH_WIDTH-1:0];
            periph_flag_reg_two_ff <= mic_pkg::RST_PERIPH_REG[PERIPH_WIDTH-1:0];
        end
        else
        begin
            periph_flag_reg_one_ff <= flag_update(periph_flag_reg_one_ff, periph_evt_one_i,
                wr_en && wr_addr == mic_pkg::ADDR_PERIPH_FLAG_REG_ONE, wr_data);
            periph_flag_reg_two_ff <= flag_update(periph_flag_reg_two_ff, periph_evt_two_i,
                wr_en && wr_addr == mic_pkg::ADDR_PERIPH_FLAG_REG_TWO, wr_data);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            periph_enable_reg_one_ff <= mic_pkg::RST_PERIPH_REG[PERIPH_WIDTH-1:0];
            periph_enable_reg_two_ff <= mic_pkg::RST_PERIPH_REG[PERIPH_WIDTH-1:0];
            option_reg_ff <= mic_pkg::RST_OPTION_REG;
        end
        else if (wr_en)
        begin
            if (wr_addr == mic_pkg::ADDR_PERIPH_ENABLE_REG_ONE)
            begin
                periph_enable_reg_one_ff <= wr_data[PERIPH_WIDTH-1:0];
            end
            if (wr_addr == mic_pkg::ADDR_PERIPH_ENABLE_REG_TWO)
            begin
                periph_enable_reg_two_ff <= wr_data[PERIPH_WIDTH-1:0];
            end
            if (wr_addr == mic_pkg::ADDR_OPTION_REG)
            begin
                option_reg_ff <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request, wake and vectoring
    // ------------------------------------------------------------------
    assign periph_pending = interrupt_control_reg_ff[mic_pkg::BIT_PERIPH_GROUP_ENABLE]
        && |((periph_flag_reg_one_ff & periph_enable_reg_one_ff)
        | (periph_flag_reg_two_ff & periph_enable_reg_two_ff));
    assign core_pending = (interrupt_control_reg_ff[mic_pkg::BIT_EXT_IRQ_FLAG]
        && interrupt_control_reg_ff[mic_pkg::BIT_EXT_IRQ_ENABLE])
        || (interrupt_control_reg_ff[mic_pkg::BIT_TIMER0_OVERFLOW_FLAG]
        && interrupt_control_reg_ff[mic_pkg::BIT_TIMER0_OVERFLOW_ENABLE])
        || (interrupt_control_reg_ff[mic_pkg::BIT_PORT_CHANGE_FLAG]
        && interrupt_control_reg_ff[mic_pkg::BIT_PORT_CHANGE_ENABLE]);
    assign any_pending = core_pending || periph_pending;

    // The request is resampled on two instruction boundaries, giving the
    // three to four cycle latency from pin edge to vector.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            req_pipe_ff <= 2'b00;
            irq_req_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            if (instr_cycle_i)
            begin
                req_pipe_ff <= {req_pipe_ff[0], any_pending
                    && interrupt_control_reg_ff[mic_pkg::BIT_GLOBAL_IRQ_ENABLE]};
            end
            irq_req_o <= req_pipe_ff[1] && any_pending
                && interrupt_control_reg_ff[mic_pkg::BIT_GLOBAL_IRQ_ENABLE] && !irq_ack_i;
            wake_o <= sleeping_i && any_pending;
        end
    end

    // Entry pushes only the return address; working state is software's job.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            vector_load_o <= 1'b0;
            push_return_o <= 1'b0;
            vector_addr_o <= mic_pkg::IRQ_VECTOR_ADDR;
        end
        else
        begin
            vector_load_o <= irq_ack_i;
            push_return_o <= irq_ack_i;
            vector_addr_o <= mic_pkg::IRQ_VECTOR_ADDR;
        end
    end
endmodule // mic_interrupt_control
`default_nettype wire

// File: sim/mic_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module mic_core_model (
    input wire logic sys_clk_i, // Clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic irq_req_i, // Request seen.
    output logic instr_cycle_o, // Boundary pulse.
    output logic irq_ack_o // Accept pulse.
);
    logic [1:0] phase_ff;
    always_ff @(posedge sys_clk_i)
        phase_ff <= rst_n_i ? phase_ff + 2'h1 : 2'h0;
    always_ff @(posedge sys_clk_i)
        instr_cycle_o <= rst_n_i && phase_ff == 2'h3;
    // A request is accepted only at a boundary, and once.
    always_ff @(posedge sys_clk_i)
        irq_ack_o <= rst_n_i && irq_req_i && instr_cycle_o && !irq_ack_o;
endmodule // mic_core_model
`default_nettype wire

// File: sim/mic_interrupt_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mic_interrupt_control_monitor (
    input wire logic sys_clk_i, // Clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic irq_ack_i, // Accept.
    input wire logic sleeping_i, // Asleep.
    input wire logic irq_req_o, // Request.
    input wire logic wake_o, // Wake.
    input wire logic vector_load_o, // Load.
    input wire logic push_return_o, // Push.
    input wire logic [12:0] vector_addr_o, // Vector.
    input wire logic s_axi_bvalid, // Write answer.
    input wire logic s_axi_awready, // Write ready.
    input wire logic s_axi_rvalid, // Read answer.
    input wire logic s_axi_arready // Read ready.
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    ack_loads_a: assert property (irq_ack_i |=> vector_load_o && push_return_o)
        else $error("no vector load after ack");
    load_cause_a: assert property (vector_load_o |-> $past(irq_ack_i) ##1 !vector_load_o)
        else $error("vector load without ack");
    vector_fixed_a: assert property (vector_addr_o == 13'h0004)
        else $error("vector address wrong");
    ack_drops_a: assert property (irq_ack_i |=> !irq_req_o)
        else $error("request stands after ack");
    reset_quiet_a: assert property ($rose(rst_n_i) |-> !irq_req_o && !wake_o)
        else $error("request out of reset");
    wake_asleep_a: assert property (wake_o |-> $past(sleeping_i))
        else $error("wake while awake");
    ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answering");
endmodule // mic_interrupt_control_monitor
bind mic_interrupt_control mic_interrupt_control_monitor u_mic_interrupt_control_monitor (.*);
`default_nettype wire

// File: sim/mic_interrupt_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mic_interrupt_control_bench;
    logic sys_clk_i = 1'h0, rst_n_i = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ext_irq_pin_i = 1'h0, timer0_rollover_i = 1'h0, sleeping_i = 1'h0;
    logic return_from_irq_instr_i = 1'h0, instr_cycle_i, irq_ack_i;
    logic [3:0] upper_port_pins_i = 4'h0;
    logic [7:0] periph_evt_one_i = 8'h00, periph_evt_two_i = 8'h00;
    logic irq_req_o, wake_o, vector_load_o, push_return_o;
    logic [12:0] vector_addr_o;
    int error_cnt = 0, cmp_count = 0, n;
    mic_interrupt_control u_mic_interrupt_control (.*);
    mic_core_model u_mic_core_model (.sys_clk_i, .rst_n_i, .irq_req_i(irq_req_o),
        .instr_cycle_o(instr_cycle_i), .irq_ack_o(irq_ack_i));
    initial
        forever #50 sys_clk_i = ~sys_clk_i;
    task automatic wrap_up;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        logic pa = 1'h1;
        logic pw = 1'h1;
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (pa || pw)
        begin
            @(negedge sys_clk_i);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge sys_clk_i);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(negedge sys_clk_i); while (!s_axi_bvalid);
        chk("bresp", r, s_axi_bresp);
        @(posedge sys_clk_i);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge sys_clk_i); while (!s_axi_arready);
        @(posedge sys_clk_i);
        s_axi_arvalid <= 1'h0;
        do @(negedge sys_clk_i); while (!s_axi_rvalid);
        chk("rdata", {24'h0, e}, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
        @(posedge sys_clk_i);
        s_axi_rready <= 1'h0;
    endtask
    // Counts boundaries from an event until the vector is loaded.
    task automatic wait_vec(output int k);
        k = 0;
        repeat (200)
        begin
            @(negedge sys_clk_i);
            if (vector_load_o === 1'h1)
                return;
            if (instr_cycle_i === 1'h1)
                k++;
        end
        k = -1;
    endtask
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        error_cnt++;
        wrap_up;
    end
    // ----
    // Tests
    // ----
    initial
    begin
        tick(5);
        rst_n_i <= 1'h1;
        rd(8'h00, 8'h00, 2'h0);
        rd(8'h14, 8'hff, 2'h0);
        rd(8'h1c, 8'h00, 2'h2);
        wr(8'h18, 8'hff, 2'h2);
        ext_irq_pin_i <= 1'h1;
        timer0_rollover_i <= 1'h1;
        upper_port_pins_i <= 4'h5;
        periph_evt_one_i <= 8'h08;
        periph_evt_two_i <= 8'h01;
        tick(1);
        timer0_rollover_i <= 1'h0;
        periph_evt_one_i <= 8'h00;
        periph_evt_two_i <= 8'h00;
        rd(8'h00, 8'h07, 2'h0);
        rd(8'h04, 8'h08, 2'h0);
        rd(8'h08, 8'h01, 2'h0);
        wr(8'h14, 8'h00);
        wr(8'h00, 8'h00);
        ext_irq_pin_i <= 1'h0;
        rd(8'h00, 8'h02, 2'h0);
        wr(8'h00, 8'h00);
        ext_irq_pin_i <= 1'h1;
        rd(8'h00, 8'h00, 2'h0);
        wr(8'h00, 8'h90);
        tick(12);
        @(negedge sys_clk_i);
        chk("irq_req", 1'h0, irq_req_o);
        tick(1);
        ext_irq_pin_i <= 1'h0;
        wait_vec(n);
        chk("latency", 1'h1, n >= 3 && n <= 4);
        chk("push", 1'h1, push_return_o);
        chk("vaddr", 13'h0004, vector_addr_o);
        rd(8'h00, 8'h12, 2'h0);
        @(negedge sys_clk_i);
        chk("irq_req", 1'h0, irq_req_o);
        wr(8'h00, 8'h10);
        return_from_irq_instr_i <= 1'h1;
        tick(1);
        return_from_irq_instr_i <= 1'h0;
        rd(8'h00, 8'h90, 2'h0);
        wr(8'h00, 8'h10);
        ext_irq_pin_i <= 1'h1;
        sleeping_i <= 1'h1;
        tick(3);
        ext_irq_pin_i <= 1'h0;
        tick(4);
        @(negedge sys_clk_i);
        chk("wake", 1'h1, wake_o);
        chk("irq_req", 1'h0, irq_req_o);
        rd(8'h18, 8'h05, 2'h0);
        sleeping_i <= 1'h0;
        wr(8'h0c, 8'h08);
        wr(8'h00, 8'hc0);
        wait_vec(n);
        chk("vector", 1'h1, n >= 0);
        rd(8'h00, 8'h40, 2'h0);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00, 2'h0);
        wr(8'h00, 8'h80);
        rst_n_i <= 1'h0;
        tick(2);
        rst_n_i <= 1'h1;
        rd(8'h00, 8'h00, 2'h0);
        rd(8'h04, 8'h00, 2'h0);
        wrap_up;
    end
endmodule // mic_interrupt_control_bench
`default_nettype wire
